// ### bench/mem_cp_model.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------
// Memory word and coprocessor bank facing the decoder
// -----------------------------------------------------------------
module mem_cp_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_mem_req,
  input wire logic i_mem_write,
  input wire logic i_mem_byte,
  input wire logic i_mem_lock,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_mem_wdata,
  input wire logic i_cp_issue,
  input wire logic [3:0] i_cp_num,
  input wire logic [15:0] i_cp_present,
  input wire logic i_cp_fault,
  input wire logic [3:0] i_ack_delay,
  output logic o_mem_ack,
  output logic [31:0] o_mem_rdata,
  output logic o_cp_accept,
  output logic o_cp_exception,
  output logic [31:0] o_mem_word,
  output logic o_proto_err
);
  logic [3:0] wait_q;
  logic [31:0] rd_q, rd_addr_q;
  logic rd_seen_q, issue_q;
  // Outside the ack the data lines show garbage, not the old value
  assign o_mem_rdata = o_mem_ack ? rd_q : ~rd_q;
  // Units ignore numbers they do not own
  assign o_cp_accept = (i_cp_issue | issue_q) & i_cp_present[i_cp_num];
  assign o_cp_exception = o_cp_accept & i_cp_fault;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mem_ack <= 1'h0;
      wait_q <= 4'h0;
      rd_q <= 32'h0;
      rd_addr_q <= 32'h0;
      rd_seen_q <= 1'h0;
      issue_q <= 1'h0;
      o_mem_word <= 32'h5a3c96e1;
      o_proto_err <= 1'h0;
    end else begin
      issue_q <= i_cp_issue;
      o_mem_ack <= 1'h0;
      if (!i_mem_req) begin
        wait_q <= 4'h0;
        rd_seen_q <= 1'h0;
      end else if (!o_mem_ack) begin
        if (wait_q != i_ack_delay) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          o_mem_ack <= 1'h1;
          wait_q <= 4'h0;
          if (i_mem_write) begin
            o_mem_word <= i_mem_byte ?
              {o_mem_word[31:8], i_mem_wdata[7:0]} : i_mem_wdata;
          end else begin
            rd_q <= o_mem_word;
            rd_seen_q <= 1'h1;
            rd_addr_q <= i_mem_addr;
          end
        end
      end
      // The bus must stay locked across both halves of a swap
      if (i_mem_req && !i_mem_lock) o_proto_err <= 1'h1;
      if (i_mem_req && i_mem_write && (!rd_seen_q ||
          i_mem_addr != rd_addr_q)) o_proto_err <= 1'h1;
    end
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------
// Decoder bench: encoding table, coprocessors, swaps, reset
// -----------------------------------------------------------------
module tb_top;
  import xdec_pkg::*;
  typedef struct {
    logic [31:0] ins;
    logic [3:0] v;
    logic p;
    instr_class_e c;
    logic [4:0] g;
    logic [31:0] f;
  } row_s;
  logic i_clk = 1'h0, i_reset, i_valid = 1'h0, i_privileged = 1'h1;
  logic cp_fault = 1'h0, proto_err;
  logic [31:0] i_instr = 32'h0, i_base_value = 32'h0;
  logic [31:0] i_source_value = 32'h0, exp_mem = 32'h5a3c96e1;
  logic [3:0] i_arch_version = 4'h4, ack_dly = 4'h0;
  logic [15:0] cp_present = 16'h8421;
  logic i_mem_ack, i_cp_accept, i_cp_exception;
  logic [31:0] i_mem_rdata, mem_word, o_mem_addr, o_mem_wdata;
  logic [31:0] o_swap_load_data, fld_s;
  logic o_mem_req, o_mem_write, o_mem_byte, o_mem_lock, o_writeback;
  logic o_user_bank, o_restore_status, o_cp_issue, o_accumulate, o_signed;
  logic o_saved_status_sel, o_undef_trap, o_unpredictable, o_busy;
  logic o_swap_done;
  logic [3:0] o_cp_num, o_reg_dest, o_reg_dest_hi, o_reg_acc, o_reg_src_a;
  logic [3:0] o_reg_src_b, o_sub_opcode, o_write_mask;
  logic [11:0] o_status_imm;
  logic [4:0] seen;
  instr_class_e o_class, cls_s;
  addr_mode_e o_addr_mode;
  reg_mask_t o_reg_list;
  int miscompares = 0, check_count = 0, cyc = 0;
  // Flags column: cp issue, user bank, restore, unpredictable, trap
  row_s rows [23] = '{
    '{32'he8bd8000, 4'h4, 1'h1, CLS_BLOCK_LOAD, 5'h00, 32'h18000},
    '{32'he9800001, 4'h4, 1'h1, CLS_BLOCK_STORE, 5'h00, 32'h20001},
    '{32'he8110006, 4'h4, 1'h1, CLS_BLOCK_LOAD, 5'h00, 32'h40006},
    '{32'he9200ff0, 4'h4, 1'h1, CLS_BLOCK_STORE, 5'h00, 32'h70ff0},
    '{32'he8dd8000, 4'h4, 1'h1, CLS_BLOCK_LOAD, 5'h04, 32'h08000},
    '{32'he8dd0001, 4'h4, 1'h1, CLS_BLOCK_LOAD, 5'h08, 32'h00001},
    '{32'he8cd0003, 4'h4, 1'h0, CLS_BLOCK_STORE, 5'h00, 32'h00003},
    '{32'he8cd0003, 4'h4, 1'h1, CLS_BLOCK_STORE, 5'h08, 32'h00003},
    '{32'he0023495, 4'h4, 1'h1, CLS_MULTIPLY, 5'h00, 32'h45230},
    '{32'he0323495, 4'h4, 1'h1, CLS_MULTIPLY, 5'h00, 32'h45231},
    '{32'he0423495, 4'h4, 1'h1, CLS_UNDEFINED, 5'h01, 32'h0},
    '{32'he0723495, 4'h3, 1'h1, CLS_NONE, 5'h02, 32'h0},
    '{32'he0823495, 4'h4, 1'h1, CLS_LONG_MULTIPLY, 5'h00, 32'h82345000},
    '{32'he0f23495, 4'h4, 1'h1, CLS_LONG_MULTIPLY, 5'h00, 32'hf2345003},
    '{32'he10f3000, 4'h4, 1'h1, CLS_READ_STATUS, 5'h00, 32'h03},
    '{32'he14f3000, 4'h4, 1'h1, CLS_READ_STATUS, 5'h00, 32'h13},
    '{32'he129f005, 4'h4, 1'h1, CLS_WRITE_STATUS_REG, 5'h00, 32'h95},
    '{32'he16cf005, 4'h4, 1'h1, CLS_WRITE_STATUS_REG, 5'h00, 32'hc5},
    '{32'he32af1ab, 4'h4, 1'h1, CLS_WRITE_STATUS_IMM, 5'h00, 32'ha1ab},
    '{32'he12fff17, 4'h4, 1'h1, CLS_BRANCH_EXCHANGE, 5'h00, 32'h7},
    '{32'he1000050, 4'h4, 1'h1, CLS_UNDEFINED, 5'h01, 32'h0},
    '{32'he3000000, 4'h3, 1'h1, CLS_NONE, 5'h02, 32'h0},
    '{32'hec000500, 4'h4, 1'h1, CLS_UNDEFINED, 5'h01, 32'h0}
  };

  always #25 i_clk = ~i_clk;

  xdec_decoder uut (.*);
  mem_cp_model mdl (
    .i_clk(i_clk), .i_reset(i_reset), .i_mem_req(o_mem_req),
    .i_mem_write(o_mem_write), .i_mem_byte(o_mem_byte),
    .i_mem_lock(o_mem_lock), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .i_cp_issue(o_cp_issue),
    .i_cp_num(o_cp_num), .i_cp_present(cp_present), .i_cp_fault(cp_fault),
    .i_ack_delay(ack_dly), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata),
    .o_cp_accept(i_cp_accept), .o_cp_exception(i_cp_exception),
    .o_mem_word(mem_word), .o_proto_err(proto_err)
  );

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cls(input instr_class_e got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: class %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] fld(instr_class_e c);
    case (c)
      CLS_BLOCK_LOAD, CLS_BLOCK_STORE:
        return {13'h0, o_addr_mode, o_writeback, o_reg_list};
      CLS_MULTIPLY: return {12'h0, o_reg_src_b, o_reg_src_a, o_reg_dest,
                            o_reg_acc, 3'h0, o_accumulate};
      CLS_LONG_MULTIPLY: return {o_sub_opcode, o_reg_dest_hi, o_reg_dest,
                                 o_reg_src_b, o_reg_src_a, 10'h0,
                                 o_accumulate, o_signed};
      CLS_WORD_SWAP, CLS_BYTE_SWAP:
        return {20'h0, o_reg_dest, o_reg_acc, o_reg_src_a};
      CLS_READ_STATUS: return {27'h0, o_saved_status_sel, o_reg_dest};
      CLS_WRITE_STATUS_REG: return {24'h0, o_write_mask, o_reg_src_a};
      CLS_WRITE_STATUS_IMM: return {16'h0, o_write_mask, o_status_imm};
      CLS_BRANCH_EXCHANGE: return {28'h0, o_reg_src_a};
      CLS_COPROC: return {28'h0, o_cp_num};
      default: return 32'h0;
    endcase
  endfunction

  // Class pulse timing is loose, so the first class seen is kept
  task automatic issue(input logic [31:0] ins, input instr_class_e ec);
    @(posedge i_clk);
    i_valid <= 1'h1;
    i_instr <= ins;
    seen = 5'h0;
    cls_s = CLS_NONE;
    fld_s = 32'h0;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      if (k == 0) i_valid <= 1'h0;
      #1;
      if (cls_s == CLS_NONE && o_class != CLS_NONE) begin
        cls_s = o_class;
        fld_s = fld(ec);
      end
      seen |= {o_cp_issue, o_user_bank, o_restore_status, o_unpredictable,
               o_undef_trap};
    end
  endtask

  task automatic swap(input logic b, input logic [3:0] d,
                      input logic [31:0] base, src);
    logic [31:0] old;
    old = exp_mem;
    @(posedge i_clk);
    ack_dly <= d;
    i_base_value <= base;
    i_source_value <= src;
    issue(b ? 32'he149c09a : 32'he109c09a, b ? CLS_BYTE_SWAP : CLS_WORD_SWAP);
    chk_cls(cls_s, b ? CLS_BYTE_SWAP : CLS_WORD_SWAP);
    chk(fld_s, 32'hc9a);
    for (int k = 0; k < 100 && o_swap_done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_swap_done, 32'h1);
    chk(o_swap_load_data, b ? {24'h0, old[7:0]} : old);
    chk(o_mem_addr, base);
    chk(o_mem_wdata, src);
    chk(o_mem_byte, b);
    exp_mem = b ? {old[31:8], src[7:0]} : src;
    chk(mem_word, exp_mem);
    @(posedge i_clk);
    #1;
    chk({o_busy, o_mem_lock, proto_err}, 32'h0);
  endtask

  initial begin
    i_reset = 1'h1;
    repeat (12) @(posedge i_clk);
    #1;
    chk_cls(o_class, CLS_NONE);
    chk({o_reg_list, o_mem_req, o_undef_trap, o_busy}, 32'h0);
    @(posedge i_clk);
    i_reset <= 1'h0;
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_arch_version <= rows[i].v;
      i_privileged <= rows[i].p;
      issue(rows[i].ins, rows[i].c);
      chk_cls(cls_s, rows[i].c);
      chk(fld_s, rows[i].f);
      chk({27'h0, seen}, {27'h0, rows[i].g});
    end
    @(posedge i_clk);
    i_arch_version <= 4'h4;
    for (int n = 0; n < 16; n++) begin
      issue(32'hee000010 | (n << 8), CLS_COPROC);
      chk_cls(cls_s, CLS_COPROC);
      chk(fld_s, n);
      chk({27'h0, seen}, {27'h0, 1'h1, 3'h0, ~cp_present[n]});
    end
    @(posedge i_clk);
    cp_fault <= 1'h1;
    issue(32'hee000510, CLS_COPROC);
    chk({27'h0, seen}, 32'h11);
    cp_fault <= 1'h0;
    swap(1'h0, 4'h1, 32'h1000, 32'hcafe0123);
    swap(1'h1, 4'h3, 32'h2001, 32'h000000a5);
    swap(1'h0, 4'h0, 32'h0ffc, 32'h5a5a0f0f);
    // Reset in mid-swap must drop the lock at once
    @(posedge i_clk);
    ack_dly <= 4'hf;
    issue(32'he109c09a, CLS_WORD_SWAP);
    chk({o_busy, o_mem_lock, o_mem_req}, 32'h7);
    @(posedge i_clk);
    i_reset <= 1'h1;
    @(posedge i_clk);
    #1;
    chk({o_busy, o_mem_lock, o_mem_req, o_swap_done}, 32'h0);
    chk_cls(o_class, CLS_NONE);
    @(posedge i_clk);
    i_reset <= 1'h0;
    exp_mem = 32'h5a3c96e1;
    swap(1'h0, 4'h2, 32'h0040, 32'h13579bdf);
    finish_test();
  end
endmodule

// ### design/xdec_consts.svh
`ifndef XDEC_CONSTS_SVH
`define XDEC_CONSTS_SVH
// Field positions of the instruction word
`define XD_LOAD_BIT 20
`define XD_WB_BIT 21
`define XD_USER_BIT 22
`define XD_UP_BIT 23
`define XD_PRE_BIT 24
`define XD_IMM_BIT 25
`define XD_BYTE_BIT 22
`define XD_PC_REG 15
// Arithmetic extension space
`define XD_ARITH_TAG 4'h9
`define XD_MUL_MAX 4'h3
`define XD_LONG_MIN 4'h8
// Control extension space
`define XD_CTRL_HI 2'h2
`define XD_ALL_ONES4 4'hf
`define XD_BX_ONES 12'hfff
`define XD_BX_TAG 4'h1
// Swap fields
`define XD_SWAP_TAG 8'h09
// Coprocessor spaces
`define XD_CP_CLASS 3'h6
`define XD_CP_OTHER 3'h7
// Lowest architecture version that traps unassigned encodings
`define XD_ARCH_TRAP 4'h4
`define XD_ARCH_RESET 4'h4
`endif

// ### design/xdec_decoder.sv
`timescale 1ns/10ps
`include "xdec_consts.svh"
// Operation
// - Register list bit n selects register n; bit 15 is the PC
// - Block load with PC and user-bank flag copies saved into current status
// - Otherwise user-bank flag in privileged mode moves user-bank registers
// - Direction bit one means block load, zero means block store
// - Pre and up bits pick the four addressing modes; writeback is separate
// - Swap is one locked read then write to the same address
// - Swap address from base; store source; load into destination
// - Coprocessor instructions carry a 4-bit number, sixteen coprocessors
// - Coprocessor instruction nobody accepts takes the undefined trap
// - Unassigned extension-space encodings raise the undefined trap on version 4 and later, else flag unpredictable
// - Arithmetic space: bits 27:24 zero and bits 7:4 equal 1001
// - Sub-opcode 0 to 3 is multiply; destination, accumulate, sources
// - Sub-opcode 8 to 15 is long multiply; two dest, two sources
// - Unassigned arithmetic encodings undefined on version 4
// - Control space: 27:26=00, 24:23=10, bit 20 clear, minus one case
// - Status read: bit 25 clear, 19:16 ones, 11:0 zero, op 00 or 10
// - Status write by register: 15:12 ones, 11:4 zero, op 01 or 11
// - Status write by immediate: bit 25 set, 15:12 ones, op 01 or 11
// - Branch exchange: 19:8 all ones, 7:4 equal 0001, op 01
// - Unassigned control encodings undefined on version 4
module xdec_decoder (
  input wire logic i_clk,
  input wire logic i_reset,
  // Instruction issue
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [3:0] i_arch_version,
  input wire logic i_privileged,
  // Coprocessor handshake
  input wire logic i_cp_accept,
  input wire logic i_cp_exception,
  // Register file values for swap
  input wire logic [31:0] i_base_value,
  input wire logic [31:0] i_source_value,
  // Memory side
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_mem_req,
  output logic o_mem_write,
  output logic o_mem_byte,
  output logic o_mem_lock,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  // Decode results
  output xdec_pkg::instr_class_e o_class,
  output xdec_pkg::addr_mode_e o_addr_mode,
  output xdec_pkg::reg_mask_t o_reg_list,
  output logic o_writeback,
  output logic o_user_bank,
  output logic o_restore_status,
  output logic [3:0] o_cp_num,
  output logic o_cp_issue,
  output logic [3:0] o_reg_dest,
  output logic [3:0] o_reg_dest_hi,
  output logic [3:0] o_reg_acc,
  output logic [3:0] o_reg_src_a,
  output logic [3:0] o_reg_src_b,
  output logic [3:0] o_sub_opcode,
  output logic o_accumulate,
  output logic o_signed,
  output logic o_saved_status_sel,
  output logic [3:0] o_write_mask,
  output logic [11:0] o_status_imm,
  output logic o_undef_trap,
  output logic o_unpredictable,
  output logic o_busy,
  output logic [31:0] o_swap_load_data,
  output logic o_swap_done
);
  import xdec_pkg::*;

  // -----------------------------------------------------------------
  // Space detection
  // -----------------------------------------------------------------
  logic [31:0] w;
  logic arith_sp, ctrl_sp, block_sp, swap_sp, cp_sp;
  logic [3:0] sub_op;
  logic [1:0] ctl_op;
  logic is_mul, is_long, is_mrs, is_msr_reg, is_msr_imm, is_bx;
  logic trap_arch, stall;
  assign w = i_instr;
  assign sub_op = w[23:20];
  assign ctl_op = w[22:21];
  assign trap_arch = (i_arch_version >= `XD_ARCH_TRAP);

  assign arith_sp = (w[27:24] == 4'h0) && (w[7:4] == `XD_ARITH_TAG);
  assign ctrl_sp = (w[27:26] == 2'h0) && (w[24:23] == `XD_CTRL_HI) &&
                   !w[20] && !(!w[25] && w[7] && w[4]);
  assign swap_sp = (w[27:23] == 5'h02) && (w[21:20] == 2'h0) &&
                   (w[11:4] == `XD_SWAP_TAG);
  assign block_sp = (w[27:25] == 3'h4);
  // Both coprocessor classes, excluding the reserved data-transfer space
  assign cp_sp = ((w[27:25] == `XD_CP_CLASS) &&
                  !(w[24] == 1'b0 && w[21] == 1'b0)) ||
                 ((w[27:25] == `XD_CP_OTHER) && !w[24]);

  assign is_mul = arith_sp && (sub_op <= `XD_MUL_MAX);
  assign is_long = arith_sp && (sub_op >= `XD_LONG_MIN);
  assign is_mrs = ctrl_sp && !w[25] && (w[19:16] == `XD_ALL_ONES4) &&
                  (w[11:0] == 12'h0) && !ctl_op[0];
  assign is_msr_reg = ctrl_sp && !w[25] &&
                      (w[15:12] == `XD_ALL_ONES4) &&
                      (w[11:4] == 8'h0) && ctl_op[0];
  assign is_msr_imm = ctrl_sp && w[25] &&
                      (w[15:12] == `XD_ALL_ONES4) && ctl_op[0];
  assign is_bx = ctrl_sp && !w[25] && (w[19:8] == `XD_BX_ONES) &&
                 (w[7:4] == `XD_BX_TAG) && (ctl_op == 2'h1);

  // -----------------------------------------------------------------
  // Classification
  // -----------------------------------------------------------------
  instr_class_e cls_d;
  logic unpred_d;
  always_comb begin
    cls_d = CLS_NONE;
    unpred_d = 1'b0;
    if (arith_sp) begin
      if (is_mul) begin
        cls_d = CLS_MULTIPLY;
      end else if (is_long) begin
        cls_d = CLS_LONG_MULTIPLY;
      end else if (trap_arch) begin
        cls_d = CLS_UNDEFINED;
      end else begin
        unpred_d = 1'b1;
      end
    end else if (swap_sp) begin
      cls_d = w[`XD_BYTE_BIT] ? CLS_BYTE_SWAP : CLS_WORD_SWAP;
    end else if (ctrl_sp) begin
      if (is_mrs) begin
        cls_d = CLS_READ_STATUS;
      end else if (is_msr_reg) begin
        cls_d = CLS_WRITE_STATUS_REG;
      end else if (is_msr_imm) begin
        cls_d = CLS_WRITE_STATUS_IMM;
      end else if (is_bx) begin
        cls_d = CLS_BRANCH_EXCHANGE;
      end else if (trap_arch) begin
        cls_d = CLS_UNDEFINED;
      end else begin
        unpred_d = 1'b1;
      end
    end else if (block_sp) begin
      cls_d = w[`XD_LOAD_BIT] ? CLS_BLOCK_LOAD : CLS_BLOCK_STORE;
    end else if (cp_sp) begin
      cls_d = CLS_COPROC;
    end else if (w[27:25] == `XD_CP_CLASS && !w[24] && !w[21]) begin
      // Reserved coprocessor extension space, nothing assigned there yet
      if (trap_arch) begin
        cls_d = CLS_UNDEFINED;
      end else begin
        unpred_d = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Swap sequencer
  // -----------------------------------------------------------------
  logic swap_start;
  assign swap_start = i_valid && !stall &&
                      (cls_d == CLS_WORD_SWAP || cls_d == CLS_BYTE_SWAP);
  xdec_swap_seq u_swap (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(swap_start),
    .i_byte(w[`XD_BYTE_BIT]),
    .i_addr(i_base_value),
    .i_store_data(i_source_value),
    .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_req(o_mem_req),
    .o_mem_write(o_mem_write),
    .o_mem_byte(o_mem_byte),
    .o_mem_lock(o_mem_lock),
    .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata),
    .o_load_data(o_swap_load_data),
    .o_busy(o_busy),
    .o_done(o_swap_done)
  );
  // No new instruction is taken while a swap owns the bus
  assign stall = o_busy;

  addr_mode_e mode_w;
  xdec_mode_sel u_mode (
    .i_pre(w[`XD_PRE_BIT]),
    .i_up(w[`XD_UP_BIT]),
    .o_mode(mode_w)
  );

  // -----------------------------------------------------------------
  // Registered decode outputs
  // -----------------------------------------------------------------
  logic take;
  logic pc_in_list;
  assign take = i_valid && !stall;
  assign pc_in_list = w[`XD_PC_REG];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_class <= CLS_NONE;
      o_unpredictable <= 1'b0;
    end else begin
      o_class <= take ? cls_d : CLS_NONE;
      o_unpredictable <= take && unpred_d;
    end
  end

  // Block transfer fields
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_list <= 16'h0;
      o_addr_mode <= INCREMENT_AFTER;
      o_writeback <= 1'b0;
      o_user_bank <= 1'b0;
      o_restore_status <= 1'b0;
    end else if (take && block_sp) begin
      o_reg_list <= w[15:0];
      o_addr_mode <= mode_w;
      o_writeback <= w[`XD_WB_BIT];
      o_restore_status <= w[`XD_LOAD_BIT] && pc_in_list &&
                          w[`XD_USER_BIT];
      o_user_bank <= w[`XD_USER_BIT] && i_privileged &&
                     !(w[`XD_LOAD_BIT] && pc_in_list);
    end else begin
      o_restore_status <= 1'b0;
      o_user_bank <= 1'b0;
    end
  end

  // Register fields for multiply, swap and status instructions
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_dest <= 4'h0;
      o_reg_dest_hi <= 4'h0;
      o_reg_acc <= 4'h0;
      o_reg_src_a <= 4'h0;
      o_reg_src_b <= 4'h0;
      o_sub_opcode <= 4'h0;
      o_accumulate <= 1'b0;
      o_signed <= 1'b0;
    end else if (take) begin
      o_sub_opcode <= sub_op;
      o_reg_src_a <= w[3:0];
      o_reg_src_b <= w[11:8];
      o_accumulate <= w[21];
      o_signed <= is_long && w[22];
      if (is_mul) begin
        o_reg_dest <= w[19:16];
        o_reg_acc <= w[15:12];
        o_reg_dest_hi <= 4'h0;
      end else if (is_long) begin
        o_reg_dest <= w[15:12];
        o_reg_dest_hi <= w[19:16];
        o_reg_acc <= 4'h0;
      end else if (swap_sp) begin
        o_reg_dest <= w[15:12];
        o_reg_acc <= w[19:16];
        o_reg_dest_hi <= 4'h0;
      end else begin
        o_reg_dest <= w[15:12];
        o_reg_acc <= 4'h0;
        o_reg_dest_hi <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_write_mask <= 4'h0;
      o_status_imm <= 12'h0;
      o_saved_status_sel <= 1'b0;
    end else if (take && ctrl_sp) begin
      o_write_mask <= w[19:16];
      o_status_imm <= w[11:0];
      o_saved_status_sel <= w[22];
    end
  end

  // -----------------------------------------------------------------
  // Coprocessor dispatch and undefined trap
  // -----------------------------------------------------------------
  // The number is broadcast with every issue; each coprocessor filters
  // on it itself, so the core never decodes which unit owns a number.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cp_num <= 4'h0;
      o_cp_issue <= 1'b0;
    end else begin
      o_cp_issue <= take && (cls_d == CLS_COPROC);
      if (take && cp_sp) begin
        o_cp_num <= w[11:8];
      end
    end
  end

  // Accept is sampled the cycle after issue; no accept means emulate.
  // A coprocessor fault after partial execution also traps.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_undef_trap <= 1'b0;
    end else begin
      o_undef_trap <= (take && cls_d == CLS_UNDEFINED) ||
                      (o_cp_issue && !i_cp_accept) ||
                      (o_cp_issue && i_cp_exception);
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_block_dir: assert property (@(posedge i_clk) disable iff (i_reset)
    take && block_sp |=> (o_class == CLS_BLOCK_LOAD) == $past(w[20]))
    else $error("block direction wrong");
  a_restore_pc: assert property (@(posedge i_clk) disable iff (i_reset)
    take && block_sp && w[20] && w[15] && w[22] |=> o_restore_status
    && !o_user_bank)
    else $error("status restore missing");
  a_user_bank: assert property (@(posedge i_clk) disable iff (i_reset)
    take && block_sp && !w[20] && w[22] && i_privileged |=> o_user_bank)
    else $error("user bank not selected");
  a_reg_list: assert property (@(posedge i_clk) disable iff (i_reset)
    take && block_sp |=> o_reg_list == $past(w[15:0]))
    else $error("register list mismatch");
  a_swap_locked: assert property (@(posedge i_clk) disable iff (i_reset)
    swap_start |=> o_mem_lock && !o_mem_write throughout
    (o_mem_lock [*1] ##0 !o_mem_write))
    else $error("swap not locked on read");
  a_swap_addr: assert property (@(posedge i_clk) disable iff (i_reset)
    swap_start |=> o_mem_addr == $past(i_base_value))
    else $error("swap address not from base");
  a_cp_undef: assert property (@(posedge i_clk) disable iff (i_reset)
    o_cp_issue && !i_cp_accept |=> o_undef_trap)
    else $error("missing coprocessor trap");
  // The trap is registered together with the class, in the same cycle
  a_arith_undef: assert property (@(posedge i_clk)
    disable iff (i_reset)
    take && arith_sp && sub_op[3:2] == 2'h1 && trap_arch
    |=> o_class == CLS_UNDEFINED && o_undef_trap)
    else $error("arith space not undefined");
  a_bx_decode: assert property (@(posedge i_clk) disable iff (i_reset)
    take && w[27:20] == 8'h12 && w[19:4] == 16'hfff1
    |=> o_class == CLS_BRANCH_EXCHANGE && o_reg_src_a == $past(w[3:0]))
    else $error("branch exchange missed");
  c_swap: cover property (@(posedge i_clk) swap_start ##[1:20] o_swap_done);
  c_cp_trap: cover property (@(posedge i_clk) o_cp_issue ##1 o_undef_trap);
  c_restore: cover property (@(posedge i_clk) o_restore_status);
endmodule

// ### design/xdec_mode_sel.sv
`timescale 1ns/10ps
`include "xdec_consts.svh"
// -----------------------------------------------------------------
// Addressing mode select for block transfers
// -----------------------------------------------------------------
module xdec_mode_sel (
  input wire logic i_pre,
  input wire logic i_up,
  output xdec_pkg::addr_mode_e o_mode
);
  import xdec_pkg::*;
  always_comb begin
    case ({i_up, i_pre})
      2'h3: o_mode = INCREMENT_BEFORE;
      2'h2: o_mode = INCREMENT_AFTER;
      2'h1: o_mode = DECREMENT_BEFORE;
      default: o_mode = DECREMENT_AFTER;
    endcase
  end
endmodule

// ### design/xdec_pkg.sv
package xdec_pkg;
  typedef enum logic [1:0] {
    INCREMENT_AFTER,
    INCREMENT_BEFORE,
    DECREMENT_AFTER,
    DECREMENT_BEFORE
  } addr_mode_e;
  typedef enum logic [3:0] {
    CLS_NONE,
    CLS_BLOCK_LOAD,
    CLS_BLOCK_STORE,
    CLS_WORD_SWAP,
    CLS_BYTE_SWAP,
    CLS_COPROC,
    CLS_MULTIPLY,
    CLS_LONG_MULTIPLY,
    CLS_READ_STATUS,
    CLS_WRITE_STATUS_REG,
    CLS_WRITE_STATUS_IMM,
    CLS_BRANCH_EXCHANGE,
    CLS_UNDEFINED
  } instr_class_e;
  typedef logic [15:0] reg_mask_t;
endpackage

// ### design/xdec_swap_seq.sv
`timescale 1ns/10ps
`include "xdec_consts.svh"
// -----------------------------------------------------------------
// Atomic swap sequencer: read then write, bus locked throughout
// -----------------------------------------------------------------
module xdec_swap_seq (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_byte,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_store_data,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_mem_req,
  output logic o_mem_write,
  output logic o_mem_byte,
  output logic o_mem_lock,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  output logic [31:0] o_load_data,
  output logic o_busy,
  output logic o_done
);
  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} swap_state_e;
  swap_state_e state_q;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: if (i_start) state_q <= S_READ;
        S_READ: if (i_mem_ack) state_q <= S_WRITE;
        S_WRITE: if (i_mem_ack) state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // Address and store value are latched once so the write reuses them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mem_addr <= 32'h0;
      o_mem_wdata <= 32'h0;
      o_mem_byte <= 1'b0;
    end else if (state_q == S_IDLE && i_start) begin
      o_mem_addr <= i_addr;
      o_mem_wdata <= i_store_data;
      o_mem_byte <= i_byte;
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_load_data <= 32'h0;
    end else if (state_q == S_READ && i_mem_ack) begin
      o_load_data <= o_mem_byte ? {24'h0, i_mem_rdata[7:0]} : i_mem_rdata;
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_done <= 1'b0;
    end else begin
      o_done <= (state_q == S_WRITE) && i_mem_ack;
    end
  end
  assign o_mem_req = (state_q != S_IDLE);
  assign o_mem_write = (state_q == S_WRITE);
  assign o_mem_lock = (state_q != S_IDLE);
  assign o_busy = (state_q != S_IDLE);
endmodule
